// ### logic/cmmc_top.sv
// Copper media mode controller with AXI4-Lite registers
// Functional notes
// - 10/100 pair A/B swap by MDI or MDI-X
// - Control bit 12 enables auto-negotiation
// - Forced speed/duplex from bits 6, 13, 8
// - Resolve speed, duplex, master role; next pages
// - Parallel detect speed when partner cannot negotiate
// - Crossover, polarity on by default; status readable
// - Detect and fix inverted polarity on four pairs
// - Auto crossover in forced 10/100 when enabled
// - Four pair arrangements including C/D swap
// - Crossover field forces MDI, MDI-X or auto
// - Downshift drops gigabit after failed attempts count
// - Leave downshift when gigabit partner appears
// - Downshift enable, count, status in bits 4:1
// - Low power idle at any speed code except 10
// - Reduced-amplitude 10 Mbps transmit select bit
// - Slave freezes timing recovery during handover
// - Master moves to recovered clock after lock
// - Two-bit reference clock select chooses mode
`timescale 1ns/1ns
`default_nettype none
module cmmc_top
  import cmmc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [1:0] reference_clock_select,
  input wire logic partner_aneg,
  input wire logic [1:0] partner_pdet_speed,
  input wire logic [3:0] partner_abil,
  input wire logic partner_np,
  input wire logic aneg_done,
  input wire logic link_ok,
  input wire logic attempt_fail,
  input wire logic [3:0] pair_inverted,
  input wire logic ring_req,
  input wire logic timing_lock,
  output logic [1:0] tx_pair_sel,
  output logic [1:0] rx_pair_sel,
  output logic cd_swap,
  output logic [3:0] pol_fix,
  output logic [1:0] op_speed,
  output logic op_duplex,
  output logic op_master,
  output logic adv_gig,
  output logic lpi_allow,
  output logic tx_10te,
  output logic tr_freeze,
  output logic tx_recovered_clk,
  output logic osc_en,
  output logic [1:0] ref_mode
);
  logic [31:0] ctrl_r, mdix_r, xovr_r, dshift_r, eee_r, abil_r, ring_r;
  logic [1:0] refsel_m_r, refsel_s_r;
  logic ref_cap_r;
  logic [3:0] in_s1_r, in_s2_r;
  logic [3:0] inv_s1_r, inv_s2_r;
  logic [1:0] pd_s1_r, pd_s2_r;
  logic [3:0] pab_s1_r, pab_s2_r;
  logic np_s1_r, np_s2_r;
  logic rr_s1_r, rr_s2_r, lk_s1_r, lk_s2_r;
  cmmc_state_e st_r;
  logic mdix_r_st, cd_r;
  logic [3:0] dwell_r;
  logic [3:0] fail_cnt_r;
  logic ds_r;
  logic aw_r, w_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aneg_on, fail_ev, done_ev, linkup, auto_x, gig_partner, ring_on;
  logic [1:0] xfield;

  function automatic logic known(input logic [7:0] a);
    known = (a == CMMC_CTRL_ADDR) || (a == CMMC_MDIX_ADDR) || (a == CMMC_XOVR_ADDR) ||
            (a == CMMC_DSHIFT_ADDR) || (a == CMMC_EEE_ADDR) || (a == CMMC_ABIL_ADDR) ||
            (a == CMMC_STAT_ADDR) || (a == CMMC_RING_ADDR);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  // Pin synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_s1_r <= 4'h0;
      in_s2_r <= 4'h0;
      inv_s1_r <= 4'h0;
      inv_s2_r <= 4'h0;
      pd_s1_r <= 2'h0;
      pd_s2_r <= 2'h0;
      pab_s1_r <= 4'h0;
      pab_s2_r <= 4'h0;
      np_s1_r <= 1'b0;
      np_s2_r <= 1'b0;
      rr_s1_r <= 1'b0;
      rr_s2_r <= 1'b0;
      lk_s1_r <= 1'b0;
      lk_s2_r <= 1'b0;
    end else if (ce) begin
      in_s1_r <= {partner_aneg, aneg_done, link_ok, attempt_fail};
      in_s2_r <= in_s1_r;
      inv_s1_r <= pair_inverted;
      inv_s2_r <= inv_s1_r;
      pd_s1_r <= partner_pdet_speed;
      pd_s2_r <= pd_s1_r;
      pab_s1_r <= partner_abil;
      pab_s2_r <= pab_s1_r;
      np_s1_r <= partner_np;
      np_s2_r <= np_s1_r;
      rr_s1_r <= ring_req;
      rr_s2_r <= rr_s1_r;
      lk_s1_r <= timing_lock;
      lk_s2_r <= lk_s1_r;
    end
  end

  // Strap sync runs through reset so release sees its settled value
  always_ff @(posedge clk) begin
    if (ce) begin
      refsel_m_r <= reference_clock_select;
      refsel_s_r <= refsel_m_r;
    end
  end

  // Reference mode latched once at first enabled edge after release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_cap_r <= 1'b0;
      ref_mode <= CMMC_REF_25_XTAL;
      osc_en <= 1'b1;
    end else if (ce && !ref_cap_r) begin
      ref_cap_r <= 1'b1;
      ref_mode <= refsel_s_r;
      osc_en <= (refsel_s_r == CMMC_REF_25_XTAL);
    end
  end

  assign aneg_on = ctrl_r[CMMC_CTRL_ANEG];
  assign xfield = xovr_r[CMMC_XOVR_LSB +: 2];
  assign fail_ev = in_s2_r[0];
  assign linkup = in_s2_r[1];
  assign done_ev = in_s2_r[2];
  assign gig_partner = pab_s2_r[3];
  // Automatic crossover active in auto-neg, or forced mode if allowed
  assign auto_x = (xfield == CMMC_XOVR_AUTO) && !mdix_r[CMMC_MDIX_XOVR_DIS] &&
                  (aneg_on || !mdix_r[CMMC_MDIX_FRC_DIS]);
  assign ring_on = ring_r[0] && (op_speed == CMMC_SPD_1000) && linkup;

  // AXI4-Lite write path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_r <= 1'b0;
      w_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CMMC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (aw_r && w_r && !s_axi_bvalid) begin
        aw_r <= 1'b0;
        w_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= known(awaddr_r) ? CMMC_RESP_OKAY : CMMC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_r && !s_axi_bvalid;
  assign s_axi_wready = !w_r && !s_axi_bvalid;

  // Register writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CMMC_CTRL_RST;
      mdix_r <= CMMC_MDIX_RST;
      xovr_r <= 32'h0000_0000;
      dshift_r <= CMMC_DSHIFT_RST;
      eee_r <= 32'h0000_0000;
      abil_r <= CMMC_ABIL_RST;
      ring_r <= 32'h0000_0000;
    end else if (ce && aw_r && w_r && !s_axi_bvalid) begin
      case (awaddr_r)
        CMMC_CTRL_ADDR: ctrl_r <= merge(ctrl_r, wdata_r, wstrb_r);
        CMMC_MDIX_ADDR: mdix_r <= merge(mdix_r, wdata_r, wstrb_r);
        CMMC_XOVR_ADDR: xovr_r <= merge(xovr_r, wdata_r, wstrb_r);
        CMMC_DSHIFT_ADDR: dshift_r <= merge(dshift_r, wdata_r, wstrb_r);
        CMMC_EEE_ADDR: eee_r <= merge(eee_r, wdata_r, wstrb_r);
        CMMC_ABIL_ADDR: abil_r <= merge(abil_r, wdata_r, wstrb_r);
        CMMC_RING_ADDR: ring_r <= merge(ring_r, wdata_r, wstrb_r);
        default: ;
      endcase
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CMMC_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known(s_axi_araddr) ? CMMC_RESP_OKAY : CMMC_RESP_SLVERR;
        case (s_axi_araddr)
          CMMC_CTRL_ADDR: s_axi_rdata <= ctrl_r;
          CMMC_MDIX_ADDR: s_axi_rdata <= mdix_r;
          CMMC_XOVR_ADDR: s_axi_rdata <= xovr_r;
          CMMC_DSHIFT_ADDR: s_axi_rdata <= {dshift_r[31:2], ds_r, dshift_r[0]};
          CMMC_EEE_ADDR: s_axi_rdata <= eee_r;
          CMMC_ABIL_ADDR: s_axi_rdata <= abil_r;
          // Status: pol fix, cd swap, mdix, speed, duplex, master, state
          CMMC_STAT_ADDR: s_axi_rdata <= {12'h000, ref_mode, st_r, pol_fix, cd_r, mdix_r_st,
                                          op_speed, op_duplex, op_master, adv_gig,
                                          tr_freeze, tx_recovered_clk, 1'b0};
          CMMC_RING_ADDR: s_axi_rdata <= ring_r;
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  // Negotiation, parallel detection and forced mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= CMMC_ST_IDLE;
      op_speed <= CMMC_SPD_10;
      op_duplex <= 1'b0;
      op_master <= 1'b0;
    end else if (ce) begin
      case (st_r)
        CMMC_ST_IDLE: begin
          if (!aneg_on) begin
            op_speed <= {ctrl_r[CMMC_CTRL_SPD_MSB], ctrl_r[CMMC_CTRL_SPD_LSB]};
            op_duplex <= ctrl_r[CMMC_CTRL_DUPLEX];
          end else if (done_ev) begin
            st_r <= in_s2_r[3] ? CMMC_ST_ANEG : CMMC_ST_PDET;
          end
        end
        CMMC_ST_ANEG: begin
          // Highest common ability wins; role held during ring handover
          // Live advertisement; the adv_gig flop lags a downshift exit
          if (abil_r[3] && !ds_r && gig_partner) begin
            op_speed <= CMMC_SPD_1000;
            op_duplex <= 1'b1;
          end else if (abil_r[2] && pab_s2_r[2]) begin
            op_speed <= CMMC_SPD_100;
            op_duplex <= abil_r[1] && pab_s2_r[1];
          end else begin
            op_speed <= CMMC_SPD_10;
            op_duplex <= abil_r[0] && pab_s2_r[0];
          end
          if (!ring_on) begin
            op_master <= abil_r[4] || !np_s2_r;
          end
          st_r <= CMMC_ST_LINK;
        end
        CMMC_ST_PDET: begin
          op_speed <= (pd_s2_r == CMMC_SPD_100) ? CMMC_SPD_100 : CMMC_SPD_10;
          op_duplex <= 1'b0;
          st_r <= CMMC_ST_LINK;
        end
        CMMC_ST_LINK: begin
          if (!linkup || !aneg_on) begin
            st_r <= CMMC_ST_IDLE;
          end
        end
        default: st_r <= CMMC_ST_IDLE;
      endcase
    end
  end

  // Crossover search across four arrangements and polarity fix
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mdix_r_st <= 1'b0;
      cd_r <= 1'b0;
      dwell_r <= 4'h0;
      pol_fix <= 4'h0;
    end else if (ce) begin
      if (xfield == CMMC_XOVR_MDI) begin
        mdix_r_st <= 1'b0;
      end else if (xfield == CMMC_XOVR_MDIX) begin
        mdix_r_st <= 1'b1;
      end else if (auto_x && !linkup && fail_ev) begin
        if (dwell_r == CMMC_XOVR_DWELL) begin
          dwell_r <= 4'h0;
          {mdix_r_st, cd_r} <= {mdix_r_st, cd_r} + 2'h1;
        end else begin
          dwell_r <= dwell_r + 4'h1;
        end
      end
      pol_fix <= mdix_r[CMMC_MDIX_POL_DIS] ? 4'h0 : inv_s2_r;
    end
  end

  // Downshift: counts failed gigabit attempts, recovers on gig partner
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fail_cnt_r <= 4'h0;
      ds_r <= 1'b0;
    end else if (ce) begin
      if (ds_r && gig_partner && done_ev) begin
        ds_r <= 1'b0;
        fail_cnt_r <= 4'h0;
      end else if (dshift_r[CMMC_DS_EN] && adv_gig && fail_ev && !linkup) begin
        if ({1'b0, fail_cnt_r[2:0]} >= {2'b00, dshift_r[CMMC_DS_CNT_LSB +: 2]} + 4'h1) begin
          ds_r <= 1'b1;
        end else begin
          fail_cnt_r <= fail_cnt_r + 4'h1;
        end
      end else if (linkup) begin
        fail_cnt_r <= 4'h0;
      end
    end
  end

  // Pair mapping and energy modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_pair_sel <= 2'h0;
      rx_pair_sel <= 2'h1;
      cd_swap <= 1'b0;
      adv_gig <= 1'b1;
      lpi_allow <= 1'b0;
      tx_10te <= 1'b0;
      tr_freeze <= 1'b0;
      tx_recovered_clk <= 1'b0;
    end else if (ce) begin
      tx_pair_sel <= mdix_r_st ? 2'h1 : 2'h0;
      rx_pair_sel <= mdix_r_st ? 2'h0 : 2'h1;
      cd_swap <= cd_r;
      adv_gig <= abil_r[3] && !ds_r;
      lpi_allow <= eee_r[0] && (op_speed != CMMC_SPD_10);
      tx_10te <= eee_r[CMMC_EEE_10TE];
      tr_freeze <= ring_on && !op_master && rr_s2_r;
      tx_recovered_clk <= ring_on && op_master && rr_s2_r && lk_s2_r;
    end
  end

  property p_pair_map;
    @(posedge clk) disable iff (rst)
      ce ##1 ce |-> (tx_pair_sel == (mdix_r_st ? 2'h1 : 2'h0)) || $changed(mdix_r_st);
  endproperty
  a_pair_map: assert property (p_pair_map) else $error("pair mapping mismatch");

  property p_forced;
    @(posedge clk) disable iff (rst)
      (ce && !aneg_on && st_r == CMMC_ST_IDLE && $stable(ctrl_r)) ##1 ce
        |-> op_duplex == $past(ctrl_r[CMMC_CTRL_DUPLEX]);
  endproperty
  a_forced: assert property (p_forced) else $error("forced duplex not applied");

  property p_force_mdi;
    @(posedge clk) disable iff (rst)
      (ce && xfield == CMMC_XOVR_MDI) |=> !mdix_r_st;
  endproperty
  a_force_mdi: assert property (p_force_mdi) else $error("MDI not forced");

  property p_lpi;
    @(posedge clk) disable iff (rst) op_speed == CMMC_SPD_10 && $stable(op_speed) |-> !lpi_allow;
  endproperty
  a_lpi: assert property (p_lpi) else $error("LPI at 10 Mbps");

  property p_ds_adv;
    @(posedge clk) disable iff (rst) (ce && ds_r) |=> !adv_gig;
  endproperty
  a_ds_adv: assert property (p_ds_adv) else $error("gig still advertised");

  property p_freeze;
    @(posedge clk) disable iff (rst) tr_freeze |-> !tx_recovered_clk;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze with recovered clock");

  sequence s_ring_master;
    ce && ring_on && op_master && rr_s2_r;
  endsequence
  property p_recov;
    @(posedge clk) disable iff (rst) (s_ring_master and (ce && lk_s2_r)) |=> tx_recovered_clk;
  endproperty
  a_recov: assert property (p_recov) else $error("no switch to recovered clock");

  property p_ref;
    @(posedge clk) disable iff (rst) ref_cap_r |=> $stable(ref_mode);
  endproperty
  a_ref: assert property (p_ref) else $error("reference mode changed");

  property p_osc;
    @(posedge clk) disable iff (rst) osc_en == (ref_mode == CMMC_REF_25_XTAL);
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator enable wrong");
endmodule
`default_nettype wire

// ### logic/cmmc_pkg.sv
// Package for the copper media mode controller
package cmmc_pkg;
  // Register byte addresses
  localparam logic [7:0] CMMC_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CMMC_MDIX_ADDR = 8'h04;
  localparam logic [7:0] CMMC_XOVR_ADDR = 8'h08;
  localparam logic [7:0] CMMC_DSHIFT_ADDR = 8'h0C;
  localparam logic [7:0] CMMC_EEE_ADDR = 8'h10;
  localparam logic [7:0] CMMC_ABIL_ADDR = 8'h14;
  localparam logic [7:0] CMMC_STAT_ADDR = 8'h18;
  localparam logic [7:0] CMMC_RING_ADDR = 8'h1C;
  // Control register bits
  localparam int CMMC_CTRL_SPD_LSB = 6;
  localparam int CMMC_CTRL_DUPLEX = 8;
  localparam int CMMC_CTRL_ANEG = 12;
  localparam int CMMC_CTRL_SPD_MSB = 13;
  localparam logic [31:0] CMMC_CTRL_RST = 32'h0000_1140;
  // Crossover and polarity config bits
  localparam int CMMC_MDIX_POL_DIS = 4;
  localparam int CMMC_MDIX_XOVR_DIS = 5;
  localparam int CMMC_MDIX_FRC_DIS = 7;
  localparam logic [31:0] CMMC_MDIX_RST = 32'h0000_0000;
  localparam int CMMC_XOVR_LSB = 2;
  localparam logic [1:0] CMMC_XOVR_AUTO = 2'h0;
  localparam logic [1:0] CMMC_XOVR_MDI = 2'h2;
  localparam logic [1:0] CMMC_XOVR_MDIX = 2'h3;
  // Downshift bits
  localparam int CMMC_DS_EN = 4;
  localparam int CMMC_DS_CNT_LSB = 2;
  localparam int CMMC_DS_STAT = 1;
  localparam logic [31:0] CMMC_DSHIFT_RST = 32'h0000_0004;
  localparam logic [31:0] CMMC_ABIL_RST = 32'h0000_000F;
  localparam int CMMC_EEE_10TE = 15;
  localparam logic [1:0] CMMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] CMMC_RESP_SLVERR = 2'h2;
  // Speed encoding
  localparam logic [1:0] CMMC_SPD_10 = 2'h0;
  localparam logic [1:0] CMMC_SPD_100 = 2'h1;
  localparam logic [1:0] CMMC_SPD_1000 = 2'h2;
  // Reference clock modes
  localparam logic [1:0] CMMC_REF_25_XTAL = 2'h0;
  localparam logic [1:0] CMMC_REF_25_EXT = 2'h1;
  localparam logic [1:0] CMMC_REF_50_EXT = 2'h2;
  localparam logic [1:0] CMMC_REF_125_EXT = 2'h3;
  // Crossover search dwell: failed link attempts per arrangement, less one
  localparam logic [3:0] CMMC_XOVR_DWELL = 4'h2;
  typedef enum logic [3:0] {
    CMMC_ST_IDLE = 4'b0001,
    CMMC_ST_ANEG = 4'b0010,
    CMMC_ST_PDET = 4'b0100,
    CMMC_ST_LINK = 4'b1000
  } cmmc_state_e;
endpackage

// ### bench/cmmc_peer.sv
// Behavioural model of the remote copper link partner
`timescale 1ns/1ns
`default_nettype none
module cmmc_peer (
  input wire logic clk,
  input wire logic rst,
  input wire logic up,
  input wire logic neg,
  input wire logic [3:0] abil,
  input wire logic np,
  input wire logic [1:0] pdet,
  input wire logic [3:0] inv,
  input wire logic ring,
  input wire logic fail_req,
  output logic partner_aneg,
  output logic [1:0] partner_pdet_speed,
  output logic [3:0] partner_abil,
  output logic partner_np,
  output logic aneg_done,
  output logic link_ok,
  output logic attempt_fail,
  output logic [3:0] pair_inverted,
  output logic ring_req,
  output logic timing_lock
);
  logic [3:0] up_cnt_r;
  logic [3:0] lock_cnt_r;
  assign partner_aneg = neg;
  assign partner_pdet_speed = pdet;
  assign partner_abil = abil;
  assign partner_np = np;
  assign pair_inverted = up ? inv : 4'h0;
  assign ring_req = ring;
  assign aneg_done = up_cnt_r >= 4'h4;
  assign link_ok = up_cnt_r >= 4'h6;
  assign timing_lock = lock_cnt_r == 4'h6;
  // Exchange finishes a few cycles after connection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      up_cnt_r <= 4'h0;
    end else if (!up) begin
      up_cnt_r <= 4'h0;
    end else if (up_cnt_r != 4'h8) begin
      up_cnt_r <= up_cnt_r + 4'h1;
    end
  end
  // Far end joins the timing handover only while linked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_cnt_r <= 4'h0;
    end else if (!(ring && link_ok)) begin
      lock_cnt_r <= 4'h0;
    end else if (lock_cnt_r != 4'h6) begin
      lock_cnt_r <= lock_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      attempt_fail <= 1'b0;
    end else begin
      attempt_fail <= fail_req;
    end
  end
endmodule
`default_nettype wire

// ### bench/cmmc_top_tb_top.sv
// Self-checking bench for the copper media mode controller
`timescale 1ns/1ns
`default_nettype none
module cmmc_top_tb_top;
  import cmmc_pkg::*;
  logic clk, rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv, d;
  logic [3:0] s_axi_wstrb, pabil, pinv, p0, partner_abil, pair_inverted, pol_fix;
  logic [1:0] s_axi_bresp, s_axi_rresp, reference_clock_select, pdet, r;
  logic up, neg, pnp, pring, pfail, partner_aneg, partner_np, aneg_done, link_ok;
  logic attempt_fail, ring_req, timing_lock, cd_swap, op_duplex, op_master, adv_gig;
  logic lpi_allow, tx_10te, tr_freeze, tx_recovered_clk, osc_en;
  logic [1:0] partner_pdet_speed, tx_pair_sel, rx_pair_sel, op_speed, ref_mode, spd;
  integer seed;
  int err_total;
  int tests_run;
  cmmc_top u_cmmc_top (.clk(clk), .rst(rst), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .reference_clock_select(reference_clock_select), .partner_aneg(partner_aneg),
    .partner_pdet_speed(partner_pdet_speed), .partner_abil(partner_abil),
    .partner_np(partner_np), .aneg_done(aneg_done), .link_ok(link_ok),
    .attempt_fail(attempt_fail), .pair_inverted(pair_inverted), .ring_req(ring_req),
    .timing_lock(timing_lock), .tx_pair_sel(tx_pair_sel), .rx_pair_sel(rx_pair_sel),
    .cd_swap(cd_swap), .pol_fix(pol_fix), .op_speed(op_speed), .op_duplex(op_duplex),
    .op_master(op_master), .adv_gig(adv_gig), .lpi_allow(lpi_allow), .tx_10te(tx_10te),
    .tr_freeze(tr_freeze), .tx_recovered_clk(tx_recovered_clk), .osc_en(osc_en),
    .ref_mode(ref_mode));
  cmmc_peer u_cmmc_peer (.clk(clk), .rst(rst), .up(up), .neg(neg), .abil(pabil), .np(pnp),
    .pdet(pdet), .inv(pinv), .ring(pring), .fail_req(pfail), .partner_aneg(partner_aneg),
    .partner_pdet_speed(partner_pdet_speed), .partner_abil(partner_abil),
    .partner_np(partner_np), .aneg_done(aneg_done), .link_ok(link_ok),
    .attempt_fail(attempt_fail), .pair_inverted(pair_inverted), .ring_req(ring_req),
    .timing_lock(timing_lock));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tend(input string name);
    $display("test %0s finished, mismatches so far %0d", name, err_total);
  endtask
  task automatic st();
    repeat (8) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv, output logic [1:0] rs);
    logic ta, tw, da, dw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= dv;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    da = 1'b0;
    dw = 1'b0;
    while (!(da && dw)) begin
      @(negedge clk);
      ta = !da && s_axi_awready === 1'b1;
      tw = !dw && s_axi_wready === 1'b1;
      @(posedge clk);
      if (ta) begin
        s_axi_awvalid <= 1'b0;
        da = 1'b1;
      end
      if (tw) begin
        s_axi_wvalid <= 1'b0;
        dw = 1'b1;
      end
    end
    do begin
      @(negedge clk);
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] dv, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
    end while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
    end while (s_axi_rvalid !== 1'b1);
    dv = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic wo(input logic [7:0] a, input logic [31:0] dv);
    wr(a, dv, r);
    cmp32({30'h0, r}, {30'h0, CMMC_RESP_OKAY});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    cmp32(d, e);
  endtask
  task automatic fail1();
    pfail <= 1'b1;
    @(posedge clk);
    pfail <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic link(input logic on);
    up <= on;
    repeat (16) @(posedge clk);
  endtask
  function automatic logic [1:0] best(input logic [3:0] a);
    if (a[3]) return CMMC_SPD_1000;
    if (a[2]) return CMMC_SPD_100;
    return CMMC_SPD_10;
  endfunction
  initial begin
    #(8 * 20000);
    err_total++;
    results();
  end
  initial begin
    seed = 32'h560DA753;
    err_total = 0;
    tests_run = 0;
    rv = $random(seed);
    reference_clock_select = rv[1:0];
    {rst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h60;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    s_axi_wstrb = 4'hF;
    {up, neg, pnp, pring, pfail, pabil, pinv, pdet} = 15'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    st();
    cmp4({3'h0, osc_en}, {3'h0, reference_clock_select === CMMC_REF_25_XTAL});
    cmp4({2'h0, ref_mode}, {2'h0, reference_clock_select});
    rc(CMMC_CTRL_ADDR, CMMC_CTRL_RST);
    rc(CMMC_MDIX_ADDR, CMMC_MDIX_RST);
    rc(CMMC_DSHIFT_ADDR, CMMC_DSHIFT_RST);
    rd(CMMC_STAT_ADDR, d, r);
    cmp32({30'h0, d[19:18]}, {30'h0, reference_clock_select});
    cmp4({tx_pair_sel, rx_pair_sel}, 4'h1);
    tend("reset");
    rd(8'h20, d, r);
    cmp32({30'h0, r}, {30'h0, CMMC_RESP_SLVERR});
    wr(8'h24, 32'hFFFF_FFFF, r);
    cmp32({30'h0, r}, {30'h0, CMMC_RESP_SLVERR});
    tend("unmapped");
    wo(CMMC_DSHIFT_ADDR, 32'h14);
    repeat (2) fail1();
    st();
    cmp4({3'h0, adv_gig}, 4'h1);
    fail1();
    st();
    cmp4({3'h0, adv_gig}, 4'h0);
    rc(CMMC_DSHIFT_ADDR, 32'h16);
    pabil <= 4'hF;
    neg <= 1'b1;
    pnp <= 1'b1;
    link(1'b1);
    cmp4({3'h0, adv_gig}, 4'h1);
    rc(CMMC_DSHIFT_ADDR, 32'h14);
    cmp4({2'h0, op_speed}, {2'h0, CMMC_SPD_1000});
    cmp4({3'h0, op_master}, 4'h0);
    tend("downshift");
    rv = $random(seed);
    pinv <= rv[3:0] | 4'h1;
    st();
    cmp4(pol_fix, rv[3:0] | 4'h1);
    wo(CMMC_MDIX_ADDR, 32'h10);
    st();
    cmp4(pol_fix, 4'h0);
    wo(CMMC_MDIX_ADDR, 32'h0);
    tend("polarity");
    wo(CMMC_RING_ADDR, 32'h1);
    pring <= 1'b1;
    st();
    cmp4({2'h0, tr_freeze, op_master}, 4'h2);
    wo(CMMC_ABIL_ADDR, 32'h1F);
    link(1'b0);
    link(1'b1);
    st();
    cmp4({2'h0, tx_recovered_clk, op_master}, 4'h3);
    pring <= 1'b0;
    wo(CMMC_RING_ADDR, 32'h0);
    tend("ring");
    for (int i = 0; i < 4; i++) begin
      link(1'b0);
      rv = $random(seed);
      pabil <= rv[3:0];
      neg <= (i != 3);
      pdet <= {1'b0, rv[4]};
      link(1'b1);
      spd = (i != 3) ? best(rv[3:0]) : {1'b0, rv[4]};
      cmp4({2'h0, op_speed}, {2'h0, spd});
    end
    tend("negotiation");
    wo(CMMC_EEE_ADDR, 32'h8001);
    st();
    cmp4({3'h0, tx_10te}, 4'h1);
    for (int i = 0; i < 3; i++) begin
      rv = $random(seed);
      spd = 2'((i + 2) % 3);
      d = {18'h0, spd[1], 4'h0, rv[0], 1'b0, spd[0], 6'h0};
      wo(CMMC_CTRL_ADDR, d);
      st();
      cmp4({2'h0, op_speed}, {2'h0, spd});
      cmp4({3'h0, op_duplex}, {3'h0, rv[0]});
      cmp4({3'h0, lpi_allow}, {3'h0, spd != CMMC_SPD_10});
      rc(CMMC_CTRL_ADDR, d);
    end
    wo(CMMC_XOVR_ADDR, {28'h0, CMMC_XOVR_MDI, 2'h0});
    st();
    cmp4({tx_pair_sel, rx_pair_sel}, 4'h1);
    wo(CMMC_XOVR_ADDR, {28'h0, CMMC_XOVR_MDIX, 2'h0});
    st();
    cmp4({tx_pair_sel, rx_pair_sel}, 4'h4);
    tend("forced");
    link(1'b0);
    wo(CMMC_XOVR_ADDR, 32'h0);
    st();
    p0 = {cd_swap, tx_pair_sel[0], rx_pair_sel[0], 1'b0};
    repeat (3) fail1();
    st();
    cmp4({3'h0, p0 !== {cd_swap, tx_pair_sel[0], rx_pair_sel[0], 1'b0}}, 4'h1);
    wo(CMMC_MDIX_ADDR, 32'h80);
    st();
    p0 = {cd_swap, tx_pair_sel[0], rx_pair_sel[0], 1'b0};
    repeat (3) fail1();
    st();
    cmp4(p0, {cd_swap, tx_pair_sel[0], rx_pair_sel[0], 1'b0});
    tend("forced crossover");
    results();
  end
endmodule
`default_nettype wire
